// ---- verilog/pcd_pkg.sv ----
package pcd_pkg;

	// ----------------------------------------------------------------
	// Register offsets (printed offsets are not all multiples of four,
	// so they are register indices; byte address is four times these).
	// ----------------------------------------------------------------
	localparam logic [7:0] FIRST_DATA_IDX   = 8'h07;
	localparam logic [7:0] SECOND_DATA_IDX  = 8'h08;
	localparam logic [7:0] THIRD_DATA_IDX   = 8'h09;
	localparam logic [7:0] FIRST_DIR_IDX    = 8'h87;
	localparam logic [7:0] SECOND_DIR_IDX   = 8'h88;
	localparam logic [7:0] THIRD_DIR_IDX    = 8'h89;
	localparam logic [7:0] ANALOG_CFG_IDX   = 8'h9f;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int         PAR_MODE_BIT     = 4;
	localparam int         ANALOG_SEL_BIT   = 0;
	localparam logic [7:0] FIRST_DIR_RST    = 8'hff;
	localparam logic [7:0] SECOND_DIR_RST   = 8'hff;
	localparam logic [7:0] THIRD_DIR_RST    = 8'h07;
	localparam logic [7:0] THIRD_DIR_WMASK  = 8'h17;
	localparam logic [7:0] ANALOG_CFG_RST   = 8'h01;
	localparam logic [7:0] ANALOG_CFG_WMASK = 8'h01;
	localparam logic [7:0] LATCH_RST        = 8'h00;

	// ----------------------------------------------------------------
	// Bus transfer codes.
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
	localparam logic [1:0] HTRANS_SEQ       = 2'h3;

	typedef enum logic [0:0] {
		PCD_IDLE = 1'b0,
		PCD_DATA = 1'b1
	} pcd_phase_e;

endpackage

// ---- verilog/pcd_sync.sv ----
`timescale 1ns/1ps

module pcd_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	// ----------------------------------------------------------------
	// Three stages; a change is accepted once stages two and three agree.
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] dout_reg;
	logic [WIDTH-1:0] agree;

	assign agree = ~(s2_reg ^ s3_reg);
	assign dout  = dout_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			dout_reg <= '0;
		end else begin
			s1_reg   <= din;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			dout_reg <= (s2_reg & agree) | (dout_reg & ~agree);
		end
	end

endmodule

// ---- verilog/pcd_port_pins.sv ----
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module pcd_port_pins
	import pcd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  firstPortIn,
	output logic      [7:0]  firstPortOut,
	output logic      [7:0]  firstPortOe,
	input  wire logic [7:0]  firstPeriphSel,
	input  wire logic [7:0]  firstPeriphOut,
	input  wire logic [7:0]  firstPeriphOe,
	output logic      [7:0]  firstPeriphIn,
	input  wire logic [7:0]  secondPortIn,
	output logic      [7:0]  secondPortOut,
	output logic      [7:0]  secondPortOe,
	input  wire logic        parDataOe,
	input  wire logic [7:0]  parDataOut,
	output logic      [7:0]  parDataIn,
	input  wire logic [2:0]  thirdPortIn,
	output logic      [2:0]  thirdPortOut,
	output logic      [2:0]  thirdPortOe,
	output logic             parallelModeSelect,
	output logic             readStrobeN,
	output logic             writeStrobeN,
	output logic             chipSelectN,
	output logic      [2:0]  thirdAnalogSel
);

	// ----------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------
	logic [7:0]  firstLatch_reg;
	logic [7:0]  secondLatch_reg;
	logic [2:0]  thirdLatch_reg;
	logic [7:0]  firstDir_reg;
	logic [7:0]  secondDir_reg;
	logic [7:0]  thirdCtl_reg;
	logic [7:0]  analogCfg_reg;
	logic [7:0]  wrIdx_reg;
	logic [31:0] hrdata_reg;
	pcd_phase_e  phase_reg;

	logic [7:0]  firstPins;
	logic [7:0]  secondPins;
	logic [7:0]  thirdPinsWide;
	logic [2:0]  thirdPins;

	// ----------------------------------------------------------------
	// Pin input synchronisers.
	// ----------------------------------------------------------------
	pcd_sync #(.WIDTH(8)) u_sync_first (
		.clk  (clk),
		.rst  (rst),
		.din  (firstPortIn),
		.dout (firstPins)
	);

	pcd_sync #(.WIDTH(8)) u_sync_second (
		.clk  (clk),
		.rst  (rst),
		.din  (secondPortIn),
		.dout (secondPins)
	);

	pcd_sync #(.WIDTH(8)) u_sync_third (
		.clk  (clk),
		.rst  (rst),
		.din  ({5'h00, thirdPortIn}),
		.dout (thirdPinsWide)
	);

	assign thirdPins = thirdPinsWide[2:0];

	// ----------------------------------------------------------------
	// Decoding.
	// ----------------------------------------------------------------
	function automatic logic [7:0] word_index(input logic [31:0] a);
		word_index = a[9:2];
	endfunction

	wire        parMode  = thirdCtl_reg[PAR_MODE_BIT];
	wire        analogOn = analogCfg_reg[ANALOG_SEL_BIT];
	wire        addrOk   = hsel & hready & htrans[1] & (haddr[1:0] == 2'h0);
	wire        wrTake   = addrOk & hwrite;
	wire        rdTake   = addrOk & ~hwrite;
	wire [7:0]  rdIdx    = word_index(haddr);
	wire        wrData   = (phase_reg == PCD_DATA);

	// Analog-selected pins read zero; the strobes see digital pins only.
	wire [2:0]  thirdRead = analogOn ? 3'h0 : thirdPins;

	// ----------------------------------------------------------------
	// Read mux: pin levels, not latches, are returned.
	// ----------------------------------------------------------------
	logic [7:0] rdByte;
	always_comb begin
		case (rdIdx)
			FIRST_DATA_IDX:  rdByte = firstPins;
			SECOND_DATA_IDX: rdByte = secondPins;
			THIRD_DATA_IDX:  rdByte = {5'h00, thirdRead};
			FIRST_DIR_IDX:   rdByte = firstDir_reg;
			SECOND_DIR_IDX:  rdByte = secondDir_reg;
			THIRD_DIR_IDX:   rdByte = thirdCtl_reg;
			ANALOG_CFG_IDX:  rdByte = analogCfg_reg;
			default:         rdByte = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus slave: zero wait states, always OKAY.
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_reg  <= PCD_IDLE;
			wrIdx_reg  <= 8'h00;
			hrdata_reg <= 32'h0000_0000;
		end else begin
			phase_reg  <= wrTake ? PCD_DATA : PCD_IDLE;
			wrIdx_reg  <= wrTake ? rdIdx : wrIdx_reg;
			hrdata_reg <= rdTake ? {24'h000000, rdByte} : hrdata_reg;
		end
	end

	// ----------------------------------------------------------------
	// Register writes.
	// ----------------------------------------------------------------
	wire wFirstD  = wrData & (wrIdx_reg == FIRST_DATA_IDX);
	wire wSecondD = wrData & (wrIdx_reg == SECOND_DATA_IDX);
	wire wThirdD  = wrData & (wrIdx_reg == THIRD_DATA_IDX);
	wire wFirstT  = wrData & (wrIdx_reg == FIRST_DIR_IDX);
	wire wSecondT = wrData & (wrIdx_reg == SECOND_DIR_IDX);
	wire wThirdT  = wrData & (wrIdx_reg == THIRD_DIR_IDX);
	wire wAnalog  = wrData & (wrIdx_reg == ANALOG_CFG_IDX);

	// A true unknown cannot be built; the latches clear on reset and
	// software must write them before turning pins to outputs.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstLatch_reg  <= LATCH_RST;
			secondLatch_reg <= LATCH_RST;
			thirdLatch_reg  <= LATCH_RST[2:0];
		end else begin
			firstLatch_reg  <= wFirstD ? hwdata[7:0] : firstLatch_reg;
			secondLatch_reg <= wSecondD ? hwdata[7:0] : secondLatch_reg;
			thirdLatch_reg  <= wThirdD ? hwdata[2:0] : thirdLatch_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstDir_reg  <= FIRST_DIR_RST;
			secondDir_reg <= SECOND_DIR_RST;
			thirdCtl_reg  <= THIRD_DIR_RST;
			analogCfg_reg <= ANALOG_CFG_RST;
		end else begin
			firstDir_reg  <= wFirstT ? hwdata[7:0] : firstDir_reg;
			secondDir_reg <= wSecondT ? hwdata[7:0] : secondDir_reg;
			thirdCtl_reg  <= wThirdT ? (hwdata[7:0] & THIRD_DIR_WMASK)
				: thirdCtl_reg;
			analogCfg_reg <= wAnalog ? (hwdata[7:0] & ANALOG_CFG_WMASK)
				: analogCfg_reg;
		end
	end

	// ----------------------------------------------------------------
	// First port: peripheral override per pin, else latch and direction.
	// Bit roles: 0 timer osc/clock, 1-2 capture/compare, 3-5 serial,
	// 6-7 USART.
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_first
			assign firstPortOut[i] = firstPeriphSel[i] ? firstPeriphOut[i]
				: firstLatch_reg[i];
			assign firstPortOe[i]  = firstPeriphSel[i] ? firstPeriphOe[i]
				: ~firstDir_reg[i];
		end
	endgenerate

	assign firstPeriphIn = firstPins;

	// ----------------------------------------------------------------
	// Second port: general pins, or the parallel data bus.
	// ----------------------------------------------------------------
	assign secondPortOut = parMode ? parDataOut : secondLatch_reg;
	assign secondPortOe  = parMode ? {8{parDataOe}}
		: ~secondDir_reg;
	assign parDataIn     = secondPins;

	// ----------------------------------------------------------------
	// Third port: direction drives pins even in analog use.
	// ----------------------------------------------------------------
	assign thirdPortOut       = thirdLatch_reg;
	assign thirdPortOe        = ~thirdCtl_reg[2:0];
	assign thirdAnalogSel     = {3{analogOn}};
	assign parallelModeSelect = parMode;

	// Strobes idle high when the mode is off so no cycle is seen.
	assign readStrobeN  = parMode ? thirdRead[0] : 1'b1;
	assign writeStrobeN = parMode ? thirdRead[1] : 1'b1;
	assign chipSelectN  = parMode ? thirdRead[2] : 1'b1;

endmodule

// ---- verif/pcd_pin_model.sv ----
`timescale 1ns/1ps

// Outside circuitry on one port: it drives every pin the block releases,
// so no pin floats and a read of a released pin has a known answer.
module pcd_pin_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] out,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] pin
);
	assign pin = (oe & out) | (~oe & ext);
endmodule

// ---- verif/pcd_port_pins_asserts.sv ----
`timescale 1ns/1ps

module pcd_port_pins_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic [7:0] firstPortOut,
	input wire logic [7:0] firstPortOe,
	input wire logic [7:0] firstPeriphSel,
	input wire logic [7:0] firstPeriphOut,
	input wire logic [7:0] firstPeriphOe,
	input wire logic [7:0] secondPortIn,
	input wire logic [7:0] secondPortOut,
	input wire logic [7:0] secondPortOe,
	input wire logic       parDataOe,
	input wire logic [7:0] parDataOut,
	input wire logic [7:0] parDataIn,
	input wire logic       parallelModeSelect,
	input wire logic       readStrobeN,
	input wire logic       writeStrobeN,
	input wire logic       chipSelectN,
	input wire logic [2:0] thirdAnalogSel
);
	logic [2:0] syncAge_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// The synchroniser restarts from zero and needs four edges to pass a
	// change, so its output is only compared once five edges have passed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncAge_reg <= 3'h0;
		end else if (syncAge_reg != 3'h5) begin
			syncAge_reg <= syncAge_reg + 3'h1;
		end
	end

	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer is not ready and okay");
	chk_periph_out: assert property (
		(firstPortOut & firstPeriphSel) == (firstPeriphOut & firstPeriphSel))
		else $error("peripheral output not on its pin");
	chk_periph_oe: assert property (
		(firstPortOe & firstPeriphSel) == (firstPeriphOe & firstPeriphSel))
		else $error("peripheral enable not on its pin");
	chk_par_oe: assert property (parallelModeSelect
		|-> secondPortOe == {8{parDataOe}})
		else $error("parallel mode direction wrong");
	chk_par_out: assert property (parallelModeSelect && parDataOe
		|-> secondPortOut == parDataOut)
		else $error("parallel data not on pins");
	chk_par_in: assert property (syncAge_reg == 3'h5
		|-> parDataIn == $past(secondPortIn, 4))
		else $error("parallel input data wrong");
	chk_strobe_idle: assert property (
		!parallelModeSelect && !$past(parallelModeSelect)
		|-> readStrobeN && writeStrobeN && chipSelectN)
		else $error("strobe active outside parallel mode");
	chk_reset_state: assert property ($fell(rst) |->
		thirdAnalogSel == 3'h7 && !parallelModeSelect && secondPortOe == 8'h00)
		else $error("state after reset wrong");

	cover property (parallelModeSelect && parDataOe);
	cover property (firstPeriphSel != 8'h00);
	cover property (thirdAnalogSel == 3'h0 && !readStrobeN);
endmodule

bind pcd_port_pins pcd_port_pins_asserts i_pcd_port_pins_asserts (.*);

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb
	import pcd_pkg::*;
;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2, cExt = 3'h0, thirdPortOut, thirdPortOe;
	logic [2:0]  thirdAnalogSel, thirdPortIn;
	logic        hreadyout, hresp, parDataOe = 1'b0, parallelModeSelect;
	logic        readStrobeN, writeStrobeN, chipSelectN;
	logic [7:0]  firstPeriphSel = 8'h00, firstPeriphOut = 8'h00;
	logic [7:0]  firstPeriphOe = 8'h00, parDataOut = 8'h00, aExt = 8'h00;
	logic [7:0]  bExt = 8'h00, firstPortOut, firstPortOe, firstPeriphIn;
	logic [7:0]  secondPortOut, secondPortOe, parDataIn;
	logic [7:0]  firstPortIn, secondPortIn;
	wire         hready = hreadyout;
	int          n_fail = 0, tests_run = 0;

	always #50 clk = ~clk;

	pcd_port_pins i_pcd_port_pins (.*);
	pcd_pin_model #(.W(8)) i_pin_a (.out(firstPortOut), .oe(firstPortOe),
		.ext(aExt), .pin(firstPortIn));
	pcd_pin_model #(.W(8)) i_pin_b (.out(secondPortOut), .oe(secondPortOe),
		.ext(bExt), .pin(secondPortIn));
	pcd_pin_model #(.W(3)) i_pin_c (.out(thirdPortOut), .oe(thirdPortOe),
		.ext(cExt), .pin(thirdPortIn));

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One single-word transfer; the address phase waits for ready.
	task automatic xfer(input logic [7:0] idx, input logic wr,
		input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		xfer(idx, 1'b0, 32'h0);
		cmp(rd, exp);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rdc(FIRST_DIR_IDX, 32'hff);
		rdc(SECOND_DIR_IDX, 32'hff);
		rdc(THIRD_DIR_IDX, 32'h07);
		rdc(8'hff, 32'h0);
		cmp(thirdAnalogSel, 3'h7);
		xfer(FIRST_DATA_IDX, 1'b1, 32'ha5);
		xfer(FIRST_DIR_IDX, 1'b1, 32'h0f);
		aExt <= 8'h3c;
		repeat (5) @(posedge clk);
		cmp(firstPortOe, 8'hf0);
		rdc(FIRST_DATA_IDX, 32'hac);
		firstPeriphSel <= 8'hff;
		firstPeriphOut <= 8'h5a;
		firstPeriphOe <= 8'h0f;
		repeat (5) @(posedge clk);
		cmp(firstPortOut, 8'h5a);
		cmp(firstPortOe, 8'h0f);
		cmp(firstPeriphIn, 8'h3a);
		firstPeriphSel <= 8'h00;
		xfer(SECOND_DATA_IDX, 1'b1, 32'hc3);
		xfer(SECOND_DIR_IDX, 1'b1, 32'h33);
		bExt <= 8'h55;
		repeat (5) @(posedge clk);
		cmp(secondPortOe, 8'hcc);
		rdc(SECOND_DATA_IDX, 32'hd1);
		xfer(THIRD_DATA_IDX, 1'b1, 32'h05);
		xfer(THIRD_DIR_IDX, 1'b1, 32'h02);
		cExt <= 3'h2;
		repeat (5) @(posedge clk);
		cmp(thirdPortOe, 3'h5);
		cmp(thirdPortOut, 3'h5);
		rdc(THIRD_DATA_IDX, 32'h0);
		xfer(ANALOG_CFG_IDX, 1'b1, 32'h0);
		repeat (5) @(posedge clk);
		rdc(THIRD_DATA_IDX, 32'h07);
		xfer(THIRD_DIR_IDX, 1'b1, 32'hff);
		rdc(THIRD_DIR_IDX, 32'h17);
		cmp(parallelModeSelect, 1'b1);
		parDataOe <= 1'b1;
		parDataOut <= 8'h96;
		repeat (2) @(posedge clk);
		cmp(secondPortOe, 8'hff);
		cmp(secondPortOut, 8'h96);
		parDataOe <= 1'b0;
		bExt <= 8'h69;
		cExt <= 3'h6;
		repeat (5) @(posedge clk);
		cmp(parDataIn, 8'h69);
		cmp({chipSelectN, writeStrobeN, readStrobeN}, 3'h6);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		cmp(thirdAnalogSel, 3'h7);
		cmp({chipSelectN, writeStrobeN, readStrobeN}, 3'h7);
		rdc(FIRST_DIR_IDX, 32'hff);
		end_sim;
	end

	// The run needs some 95 cycles; the limit leaves wide margin.
	initial begin
		#(4000 * 100);
		n_fail++;
		end_sim;
	end
endmodule
